// [rael_regs.svh]
// Register offsets, field positions and timing constants of the log block.
// Assumes a 200 MHz system clock and a 32-bit Wishbone register window.
`ifndef RAEL_REGS_SVH
`define RAEL_REGS_SVH
// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define RAEL_REG_CTRL 8'h00
`define RAEL_REG_STAT 8'h04
`define RAEL_REG_TIME 8'h08
`define RAEL_REG_BIN0 8'h10
`define RAEL_REG_BIN1 8'h14
`define RAEL_REG_BIN2 8'h18
`define RAEL_REG_BIN3 8'h1c
// ----------------------------------------------------------------------
// Control bits
// ----------------------------------------------------------------------
`define RAEL_C_TRIG 0
`define RAEL_C_SERVICE 1
`define RAEL_C_COMM_LOST 2
`define RAEL_C_RS_ON 3
`define RAEL_C_ERR 4
`define RAEL_C_RESTART 5
`define RAEL_C_LAUNCH 6
// ----------------------------------------------------------------------
// Log image and readout
// ----------------------------------------------------------------------
`define RAEL_CMD_READLOG 8'hf0
`define RAEL_MAX_LEN 8'h20
`define RAEL_PAGES 3'h5
`define RAEL_LAST_PAGE 3'h4
`define RAEL_PAGE_SH 4
`define RAEL_SNAP_LAST 4'hf
`define RAEL_IMG_AW 11
`define RAEL_ADDR_HI 3'h5
`define RAEL_BLINK_BIT 8
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RAEL_CLK_MHZ 200
`define RAEL_READY_MS 100
`define RAEL_PULSE_MS 1
`define RAEL_US_PER_MS 1000
`endif

// [rael_pkg.sv]
// Types shared by the rectifier alarm and event log block.
// Assumes it is compiled before the block that imports it.
package rael_pkg;
  // --------------------------------------------------------------------
  // Unit condition, indicator and alarm groups
  // --------------------------------------------------------------------
  typedef struct packed {
    logic ac_present;
    logic ac_in_limits;
    logic fuse_blown;
    logic boost_fail;
    logic ov_latched;
    logic therm_warn;
    logic therm_shut;
    logic over_current;
    logic internal_fail;
    logic [1:0] fans_failed;
  } rael_cond_t;
  typedef struct packed {
    logic input_ok;
    logic output_ok;
    logic service;
    logic fault;
  } rael_led_t;
  typedef struct packed {
    logic fault_n;
    logic overheat_warning_n;
    logic output_loss_warning_n;
  } rael_alarm_t;
  typedef enum {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK
  } rael_i2c_st_t;
  // CRC-8 with polynomial x^8+x^2+x+1, one byte at a time
  function automatic logic [7:0] rael_crc8(input logic [7:0] c,
                                           input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
    end
    return r;
  endfunction : rael_crc8
endpackage : rael_pkg

// [rael_top.sv]
// Alarm indicators, rolling event log, usage bins and log readout port.
// Assumes condition inputs come from logic on clk_i; pins are synchronised.
`timescale 1ns/100ps
`include "rael_regs.svh"
// Contract
// - After reprogram error, never launch application; a restart write clears boot_lock_q, then launch is accepted
// - Each trigger stores one stamped snapshot, five pages; a trigger while a snapshot is being written is dropped
// - Full log overwrites the oldest page
// - Accumulate time per load range bin
// - Readout: command, offset high, low, count
// - On failure return zero length and code
// - Thermal prealarm: amber on, overheat warning low
// - Shutdown faults: red, fault and power-good low
// - AC out of limits blinks input; absent dark
// - Overcurrent blinks output, pulses power-good 1 ms
// - Internal failure: red, fault low, power-good high
// - PMBus service request blinks amber
// - RS485 communication loss blinks red
// - One fan runs on; two fans shut down
// - Fault alarm idles high, low on failure
// - Overheat warning low before thermal shutdown
// - Power-good low when output loss imminent
// - Output on only with control input grounded; RS485 mode uses rs_on_q instead
// - Protocol input open selects PMBus, else RS485
// - Address low bits from position inputs
// - Interlock pin gates the main output
module rael_top
  import rael_pkg::*;
#(
  parameter int MS_CYC = `RAEL_CLK_MHZ * `RAEL_US_PER_MS * `RAEL_PULSE_MS,
  parameter int READY_CYC = `RAEL_CLK_MHZ * `RAEL_US_PER_MS * `RAEL_READY_MS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire rael_cond_t cond_i,
  input wire logic [1:0] load_range_i,
  input wire logic on_off_n_i,
  input wire logic interlock_n_i,
  input wire logic protocol_open_i,
  input wire logic [1:0] unit_position_select_i,
  input wire logic [1:0] shelf_position_select_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output rael_led_t led_o,
  output rael_alarm_t alarm_o,
  output logic slot_occupied_o,
  output logic main_output_en_o,
  output logic app_start_o
);
  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [8:0] pin_raw, pin_s1_q, pin_s2_q;
  logic scl_q, sda_q, scl_p_q, sda_p_q;
  logic on_lvl, intl_lvl, pmbus_mode;
  logic [3:0] addr_lo;
  assign pin_raw = {scl_i, sda_i, on_off_n_i, interlock_n_i, protocol_open_i,
                    unit_position_select_i, shelf_position_select_i};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_q <= 9'h1ff;
      pin_s2_q <= 9'h1ff;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      scl_p_q <= pin_s2_q[8];
      sda_p_q <= pin_s2_q[7];
    end
  end
  assign scl_q = pin_s2_q[8];
  assign sda_q = pin_s2_q[7];
  assign on_lvl = ~pin_s2_q[6];
  assign intl_lvl = ~pin_s2_q[5];
  assign pmbus_mode = pin_s2_q[4];
  assign addr_lo = pin_s2_q[3:0];

  // ----------------------------------------------------------------------
  // Millisecond and blink timing
  // ----------------------------------------------------------------------
  logic [31:0] half_cnt_q, time_q;
  logic half_tick, ms_tick, pulse_q;
  logic [8:0] ms_cnt_q;
  logic blink;
  assign half_tick = (half_cnt_q == 32'(MS_CYC / 2 - 1));
  assign ms_tick = half_tick & pulse_q;
  assign blink = ms_cnt_q[`RAEL_BLINK_BIT];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      half_cnt_q <= 32'h0;
      pulse_q <= 1'b0;
      ms_cnt_q <= 9'h0;
    end else begin
      half_cnt_q <= half_tick ? 32'h0 : half_cnt_q + 32'h1;
      if (half_tick) begin
        pulse_q <= ~pulse_q;
      end
      if (ms_tick) begin
        ms_cnt_q <= ms_cnt_q + 9'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Wishbone slave and control
  // ----------------------------------------------------------------------
  logic wr_en, ctrl_wr, service_q, comm_lost_q, rs_on_q;
  logic boot_lock_q, app_run_q, trig_sw;
  logic [31:0] bin_q [0:3];
  logic [31:0] stat_w, rd_mux;
  logic snap_busy_q, ready_q;
  logic [2:0] wr_page_q, pages_used_q;
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign ctrl_wr = wr_en & (wb_adr_i == `RAEL_REG_CTRL) & wb_sel_i[0];
  assign trig_sw = ctrl_wr & wb_dat_i[`RAEL_C_TRIG];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= rd_mux;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      service_q <= 1'b0;
      comm_lost_q <= 1'b0;
      rs_on_q <= 1'b0;
    end else if (ctrl_wr) begin
      service_q <= wb_dat_i[`RAEL_C_SERVICE];
      comm_lost_q <= wb_dat_i[`RAEL_C_COMM_LOST];
      rs_on_q <= wb_dat_i[`RAEL_C_RS_ON];
    end
  end
  // Error sticks until a restart; a new error in the same write wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_lock_q <= 1'b0;
      app_run_q <= 1'b0;
    end else if (ctrl_wr) begin
      if (wb_dat_i[`RAEL_C_ERR]) begin
        boot_lock_q <= 1'b1;
        app_run_q <= 1'b0;
      end else if (wb_dat_i[`RAEL_C_RESTART]) begin
        boot_lock_q <= 1'b0;
        app_run_q <= 1'b0;
      end else if (wb_dat_i[`RAEL_C_LAUNCH] && !boot_lock_q) begin
        app_run_q <= 1'b1;
      end
    end
  end
  assign app_start_o = app_run_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      time_q <= 32'h0;
    end else if (wr_en && wb_adr_i == `RAEL_REG_TIME) begin
      for (int b = 0; b < 4; b++) begin
        time_q[8*b +: 8] <= wb_sel_i[b] ? wb_dat_i[8*b +: 8] :
                            time_q[8*b +: 8];
      end
    end else if (ms_tick) begin
      time_q <= time_q + 32'h1;
    end
  end
  assign stat_w = {12'h0, app_run_q, boot_lock_q, snap_busy_q, ready_q,
                   pmbus_mode, pages_used_q, wr_page_q, 1'b0, led_o, 1'b0,
                   alarm_o};
  always_comb begin
    case (wb_adr_i)
      `RAEL_REG_CTRL: rd_mux = {25'h0, 3'h0, rs_on_q, comm_lost_q,
                                service_q, 1'b0};
      `RAEL_REG_STAT: rd_mux = stat_w;
      `RAEL_REG_TIME: rd_mux = time_q;
      `RAEL_REG_BIN0: rd_mux = bin_q[0];
      `RAEL_REG_BIN1: rd_mux = bin_q[1];
      `RAEL_REG_BIN2: rd_mux = bin_q[2];
      `RAEL_REG_BIN3: rd_mux = bin_q[3];
      default: rd_mux = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Alarms, indicators and output enable
  // ----------------------------------------------------------------------
  logic shut, out_on;
  rael_led_t led_d;
  rael_alarm_t al_d;
  assign shut = cond_i.fuse_blown | cond_i.boost_fail | cond_i.ov_latched |
                cond_i.therm_shut | (cond_i.fans_failed >= 2'h2);
  assign out_on = (pmbus_mode ? on_lvl : rs_on_q) & intl_lvl & ~shut &
                  cond_i.ac_present & cond_i.ac_in_limits &
                  ~boot_lock_q;
  always_comb begin
    led_d = '{input_ok: 1'b1, output_ok: out_on, service: 1'b0,
              fault: 1'b0};
    al_d = '{fault_n: 1'b1, overheat_warning_n: 1'b1,
             output_loss_warning_n: out_on};
    if (pmbus_mode && service_q) begin
      led_d.service = blink;
    end
    if (!pmbus_mode && comm_lost_q) begin
      led_d.fault = blink;
    end
    if (cond_i.internal_fail) begin
      led_d.fault = 1'b1;
      al_d.fault_n = 1'b0;
    end
    if (cond_i.therm_warn) begin
      led_d.service = 1'b1;
      al_d.overheat_warning_n = 1'b0;
    end
    if (cond_i.over_current) begin
      led_d.output_ok = blink;
      al_d.output_loss_warning_n = pulse_q;
    end
    if (shut) begin
      led_d.output_ok = 1'b0;
      led_d.fault = 1'b1;
      al_d.fault_n = 1'b0;
      al_d.output_loss_warning_n = 1'b0;
      if (cond_i.therm_shut) begin
        led_d.service = 1'b1;
        al_d.overheat_warning_n = 1'b0;
      end
    end
    if (!cond_i.ac_in_limits) begin
      led_d = '{input_ok: blink, output_ok: 1'b0, service: 1'b0,
                fault: 1'b0};
      al_d = '{fault_n: 1'b1, overheat_warning_n: 1'b1,
               output_loss_warning_n: 1'b0};
    end
    if (!cond_i.ac_present) begin
      led_d = '0;
      al_d.output_loss_warning_n = 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      led_o <= '0;
      alarm_o <= '{fault_n: 1'b1, overheat_warning_n: 1'b1,
                   output_loss_warning_n: 1'b0};
      main_output_en_o <= 1'b0;
    end else begin
      led_o <= led_d;
      alarm_o <= al_d;
      main_output_en_o <= out_on;
    end
  end
  assign slot_occupied_o = 1'b0;

  // ----------------------------------------------------------------------
  // Usage bins
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) begin
        bin_q[i] <= 32'h0;
      end
    end else if (ms_tick && out_on) begin
      bin_q[load_range_i] <= bin_q[load_range_i] + 32'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Snapshot writer, one byte per cycle into the log image
  // ----------------------------------------------------------------------
  logic [7:0] img_q [0:(1 << `RAEL_IMG_AW) - 1];
  logic [3:0] snap_idx_q;
  logic [31:0] snap_ts_q;
  logic fault_seen_q, trig;
  logic [7:0] snap_byte;
  logic [`RAEL_IMG_AW-1:0] snap_addr;
  assign trig = trig_sw | (~alarm_o.fault_n & ~fault_seen_q);
  assign snap_addr = {4'h0, wr_page_q, snap_idx_q};
  always_comb begin
    case (snap_idx_q)
      4'h0: snap_byte = snap_ts_q[31:24];
      4'h1: snap_byte = snap_ts_q[23:16];
      4'h2: snap_byte = snap_ts_q[15:8];
      4'h3: snap_byte = snap_ts_q[7:0];
      4'h4: snap_byte = {5'h0, cond_i[10:8]};
      4'h5: snap_byte = cond_i[7:0];
      4'h6: snap_byte = {1'b0, alarm_o, led_o};
      4'h7: snap_byte = {pmbus_mode, out_on, 4'h0, load_range_i};
      default: snap_byte = 8'h0;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      snap_busy_q <= 1'b0;
      snap_idx_q <= 4'h0;
      snap_ts_q <= 32'h0;
      wr_page_q <= 3'h0;
      pages_used_q <= 3'h0;
      fault_seen_q <= 1'b0;
    end else begin
      fault_seen_q <= ~alarm_o.fault_n;
      if (!snap_busy_q && trig) begin
        snap_busy_q <= 1'b1;
        snap_idx_q <= 4'h0;
        snap_ts_q <= time_q;
      end else if (snap_busy_q) begin
        snap_idx_q <= snap_idx_q + 4'h1;
        if (snap_idx_q == `RAEL_SNAP_LAST) begin
          snap_busy_q <= 1'b0;
          wr_page_q <= (wr_page_q == `RAEL_LAST_PAGE) ? 3'h0 :
                       wr_page_q + 3'h1;
          if (pages_used_q != `RAEL_PAGES) begin
            pages_used_q <= pages_used_q + 3'h1;
          end
        end
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (snap_busy_q) begin
      img_q[snap_addr] <= snap_byte;
    end
  end
  // Image is not cleared at reset; a real part keeps it nonvolatile
  logic [`RAEL_IMG_AW-1:0] rd_addr;
  logic [7:0] img_rd_q;
  always_ff @(posedge clk_i) begin
    img_rd_q <= img_q[rd_addr];
  end

  // ----------------------------------------------------------------------
  // Bus slave for the log readout
  // ----------------------------------------------------------------------
  rael_i2c_st_t st_q;
  logic scl_rise, scl_fall, start_c, stop_c, rw_q, nack_q, drv_low_q;
  logic [7:0] sh_q, cmd_q, len_q, rd_len_q, crc_q, tx_byte;
  logic [15:0] off_q;
  logic [3:0] bit_q;
  logic [1:0] rx_idx_q;
  logic [5:0] tx_idx_q;
  logic [31:0] ready_cnt_q;
  assign scl_rise = scl_q & ~scl_p_q;
  assign scl_fall = ~scl_q & scl_p_q;
  assign start_c = scl_q & scl_p_q & sda_p_q & ~sda_q;
  assign stop_c = scl_q & scl_p_q & ~sda_p_q & sda_q;
  assign rd_addr = off_q[`RAEL_IMG_AW-1:0] +
                   `RAEL_IMG_AW'(tx_idx_q - 6'h1);
  always_comb begin
    if (tx_idx_q == 6'h0) begin
      tx_byte = rd_len_q;
    end else if (tx_idx_q <= rd_len_q[5:0]) begin
      tx_byte = img_rd_q;
    end else begin
      tx_byte = crc_q;
    end
  end
  // Data is ready only after the gather delay; early reads get length 0
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_cnt_q <= 32'h0;
      ready_q <= 1'b0;
    end else if (st_q == ST_RX_ACK && rx_idx_q == 2'h3 && scl_fall) begin
      ready_cnt_q <= 32'h0;
      ready_q <= 1'b0;
    end else if (!ready_q) begin
      ready_cnt_q <= ready_cnt_q + 32'h1;
      ready_q <= (ready_cnt_q == 32'(READY_CYC - 1));
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      sh_q <= 8'h0;
      bit_q <= 4'h0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      drv_low_q <= 1'b0;
      cmd_q <= 8'h0;
      off_q <= 16'h0;
      len_q <= 8'h0;
      rd_len_q <= 8'h0;
      crc_q <= 8'h0;
      rx_idx_q <= 2'h0;
      tx_idx_q <= 6'h0;
    end else if (start_c) begin
      st_q <= ST_ADDR;
      bit_q <= 4'h0;
      drv_low_q <= 1'b0;
    end else if (stop_c) begin
      st_q <= ST_IDLE;
      drv_low_q <= 1'b0;
    end else if (scl_rise) begin
      if (st_q == ST_ADDR || st_q == ST_RX) begin
        sh_q <= {sh_q[6:0], sda_q};
        bit_q <= bit_q + 4'h1;
      end else if (st_q == ST_TX_ACK) begin
        nack_q <= sda_q;
      end
    end else if (scl_fall) begin
      case (st_q)
        ST_ADDR: if (bit_q == 4'h8) begin
          if (sh_q[7:1] == {`RAEL_ADDR_HI, addr_lo}) begin
            st_q <= ST_ADDR_ACK;
            drv_low_q <= 1'b1;
            rw_q <= sh_q[0];
            crc_q <= rael_crc8(sh_q[0] ? crc_q : 8'h0, sh_q);
            rx_idx_q <= 2'h0;
            tx_idx_q <= 6'h0;
            rd_len_q <= (ready_q && cmd_q == `RAEL_CMD_READLOG &&
                         len_q <= `RAEL_MAX_LEN) ? len_q : 8'h0;
          end else begin
            st_q <= ST_IDLE;
          end
        end
        ST_ADDR_ACK, ST_TX_ACK: begin
          bit_q <= 4'h0;
          if (!rw_q) begin
            st_q <= ST_RX;
            drv_low_q <= 1'b0;
          end else if (st_q == ST_TX_ACK && nack_q) begin
            st_q <= ST_IDLE;
            drv_low_q <= 1'b0;
          end else begin
            st_q <= ST_TX;
            sh_q <= tx_byte;
            drv_low_q <= ~tx_byte[7];
            tx_idx_q <= (st_q == ST_ADDR_ACK) ? 6'h1 : tx_idx_q + 6'h1;
            crc_q <= rael_crc8(crc_q, tx_byte);
          end
        end
        ST_RX: if (bit_q == 4'h8) begin
          st_q <= ST_RX_ACK;
          drv_low_q <= 1'b1;
          crc_q <= rael_crc8(crc_q, sh_q);
          rx_idx_q <= rx_idx_q + 2'h1;
          case (rx_idx_q)
            2'h0: cmd_q <= sh_q;
            2'h1: off_q[15:8] <= sh_q;
            2'h2: off_q[7:0] <= sh_q;
            default: len_q <= sh_q;
          endcase
        end
        ST_RX_ACK: begin
          st_q <= ST_RX;
          bit_q <= 4'h0;
          drv_low_q <= 1'b0;
        end
        ST_TX: begin
          if (bit_q == 4'h7) begin
            st_q <= ST_TX_ACK;
            drv_low_q <= 1'b0;
          end else begin
            sh_q <= {sh_q[6:0], 1'b0};
            drv_low_q <= ~sh_q[6];
            bit_q <= bit_q + 4'h1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
  assign sda_o = 1'b0;
  assign sda_oe_o = drv_low_q;
  // Readout index starts at 1 in the first data byte; length leads

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  boot_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
    boot_lock_q |=> !app_start_o)
    else $error("application started while loader locked");
  page_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_page_q < `RAEL_PAGES)
    else $error("log page out of range");
  page_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    snap_busy_q && snap_idx_q == `RAEL_SNAP_LAST &&
    wr_page_q == `RAEL_LAST_PAGE |=> wr_page_q == 3'h0)
    else $error("log did not wrap to oldest page");
  bin_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ms_tick && out_on |=> bin_q[$past(load_range_i)] ==
    $past(bin_q[load_range_i]) + 32'h1)
    else $error("usage bin missed a tick");
  zero_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(st_q == ST_ADDR_ACK) && rw_q && !$past(ready_q) |->
    rd_len_q == 8'h0)
    else $error("length not zero before data ready");
  shut_alarm_a: assert property (@(posedge clk_i) disable iff (rst_i)
    shut && cond_i.ac_present && cond_i.ac_in_limits |=>
    !alarm_o.fault_n && !alarm_o.output_loss_warning_n && led_o.fault)
    else $error("shutdown not reported");
  overheat_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cond_i.therm_warn && cond_i.ac_present && cond_i.ac_in_limits |=>
    !alarm_o.overheat_warning_n && led_o.service)
    else $error("overheat warning not driven");
  pg_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cond_i.over_current && !shut && cond_i.ac_in_limits &&
    cond_i.ac_present && half_tick ##1 cond_i.over_current &&
    !shut && cond_i.ac_in_limits && cond_i.ac_present |=>
    alarm_o.output_loss_warning_n != $past(alarm_o.output_loss_warning_n))
    else $error("power good not pulsing in overload");
  out_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !intl_lvl |=> !main_output_en_o)
    else $error("output enabled without interlock");
endmodule : rael_top

// [rael_host.sv]
// Host model that reads the event log back over the two-wire bus.
// Assumes the bench resolves SDA with a pull-up from all enables.
`timescale 1ns/100ps
module rael_host (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic qt;
    #12;
  endtask : qt
  // One SCL period of 48 ns; a != e while SCL high gives start or stop
  task automatic bt(input logic a, input logic e, output logic r);
    scl_o <= 1'b0;
    qt();
    sda_oe_o <= a;
    qt();
    scl_o <= 1'b1;
    qt();
    r = sda_i;
    sda_oe_o <= e;
    qt();
  endtask : bt
  task automatic bx(input logic [7:0] w, input logic k,
                    output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bt(!w[i], !w[i], r[i]);
    end
    bt(!k, !k, a);
  endtask : bx
  task automatic readlog(input logic [6:0] ad, input logic [7:0] c,
                         input logic [15:0] o, input logic [7:0] n,
                         input int w, output logic [7:0] q[$]);
    logic [7:0] r;
    logic a;
    int k;
    q = {};
    bt(1'b0, 1'b1, a);
    bx({ad, 1'b0}, 1'b1, r);
    bx(c, 1'b1, r);
    bx(o[15:8], 1'b1, r);
    bx(o[7:0], 1'b1, r);
    bx(n, 1'b1, r);
    repeat (w) @(posedge clk_i);
    bt(1'b0, 1'b1, a);
    bx({ad, 1'b1}, 1'b1, r);
    bx(8'hff, 1'b0, r);
    q.push_back(r);
    // Cap the count so a corrupt length cannot hang the bus
    k = (r > 8'h20) ? 32 : r;
    for (int i = 0; i <= k; i++) begin
      bx(8'hff, i == k, r);
      q.push_back(r);
    end
    bt(1'b1, 1'b0, a);
  endtask : readlog
endmodule : rael_host

// [tb_rael_top.sv]
// Self-checking bench of the alarm, event log and readout block.
// Assumes the package, the design and the host model compile first.
`timescale 1ns/100ps
module tb_rael_top;
  import rael_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] dwr = 32'h0, rdat;
  logic we = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic [10:0] cnd = 11'h600;
  logic [1:0] rng, unit, shelf;
  logic on_n = 1'b0, ilk_n = 1'b0, prot = 1'b1;
  logic [31:0] seed = 32'ha9b9c713;
  logic [6:0] ad;
  logic [31:0] exp_q[$], got_q[$];
  int fail_count = 0;
  int checked = 0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, sda_oe, host_oe, scl, slot, out_en, app;
  rael_led_t led;
  rael_alarm_t alm;
  wire sda = !(sda_oe | host_oe);
  logic [10:0] cl[9] = '{11'h600, 11'h620, 11'h700, 11'h680, 11'h640,
                         11'h604, 11'h000, 11'h602, 11'h601};
  logic [6:0] ol[9] = '{7'h67, 7'h75, 7'h4a, 7'h4a, 7'h4a,
                        7'h6b, 7'h06, 7'h4a, 7'h67};
  rael_top #(.MS_CYC(20), .READY_CYC(200)) DUT (.clk_i(clk_i),
    .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dwr), .wb_sel_i(4'hf),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cond_i(cnd), .load_range_i(rng),
    .on_off_n_i(on_n), .interlock_n_i(ilk_n), .protocol_open_i(prot),
    .unit_position_select_i(unit), .shelf_position_select_i(shelf),
    .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .led_o(led),
    .alarm_o(alm), .slot_occupied_o(slot), .main_output_en_o(out_en),
    .app_start_o(app));
  rael_host host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl),
    .sda_oe_o(host_oe));
  initial begin
    forever #2.5 clk_i = !clk_i;
  end
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic logic [7:0] crc(input logic [7:0] c,
                                     input logic [7:0] d);
    c = c ^ d;
    repeat (8)
      c = c[7] ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
    return c;
  endfunction : crc
  task automatic ex(input logic [31:0] e, input logic [31:0] g);
    exp_q.push_back(e);
    got_q.push_back(g);
  endtask : ex
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  always @(posedge clk_i) begin
    if (got_q.size() > 0) chk(exp_q.pop_front(), got_q.pop_front());
  end
  // Answer waits are unbounded here; the watchdog cuts a hang short
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    {cyc, stb, we, adr, dwr} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task automatic rd(input logic [7:0] c, input logic [15:0] o,
                    input logic [7:0] n, input logic [7:0] d, input int w);
    logic [7:0] q[$];
    logic [7:0] p, l;
    host.readlog(ad, c, o, n, w, q);
    l = (c == 8'hf0 && n <= 8'h20 && w > 200) ? n : 8'h00;
    p = crc(crc(crc(8'h00, {ad, 1'b0}), c), o[15:8]);
    p = crc(crc(crc(crc(p, o[7:0]), n), {ad, 1'b1}), l);
    ex(l, q[0]);
    if (l != 8'h00) ex(d, q[1]);
    ex(l != 8'h00 ? crc(p, d) : p, l != 8'h00 ? q[2] : q[1]);
  endtask : rd
  task automatic stop_test;
    $display("Mismatches %0d of %0d checks", fail_count, checked);
    if (fail_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  initial begin
    repeat (60000) @(posedge clk_i);
    fail_count++;
    stop_test();
  end
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    seed = xs(seed);
    {rng, shelf, unit} = seed[5:0];
    ad = {3'b101, unit, shelf};
    repeat (20) @(posedge clk_i);
    ex(10'h030, {led, alm, out_en, app, slot});
    rst_i <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      {on_n, ilk_n} <= {i == 1, i == 2};
      repeat (10) @(posedge clk_i);
      ex(i == 0, out_en);
    end
    {on_n, ilk_n} <= 2'b00;
    for (int i = 0; i < 6; i++) begin
      if (i == 5) cnd <= 11'h620;
      repeat (10) @(posedge clk_i);
      wb(1'b1, 8'h00, 32'h1, rdat);
      repeat (30) @(posedge clk_i);
    end
    cnd <= 11'h600;
    wb(1'b0, 8'h04, 32'h0, rdat);
    ex(7'h69, rdat[15:9]);
    wb(1'b0, 8'h40, 32'h0, rdat);
    ex(32'h0, rdat);
    rd(8'hf0, 16'h0006, 8'h01, 8'h5e, 250);
    rd(8'hf0, 16'h0816, 8'h01, 8'h7c, 250);
    rd(8'h55, 16'h0006, 8'h01, 8'h00, 250);
    rd(8'hf0, 16'h0006, 8'h21, 8'h00, 250);
    rd(8'hf0, 16'h0006, 8'h01, 8'h5e, 0);
    for (int i = 0; i < 9; i++) begin
      cnd <= cl[i];
      repeat (8) @(posedge clk_i);
      ex(ol[i], {led, alm});
    end
    cnd <= 11'h608;
    repeat (40) @(posedge clk_i);
    cnd <= 11'h600;
    wb(1'b1, 8'h00, 32'h10, rdat);
    wb(1'b1, 8'h00, 32'h40, rdat);
    repeat (4) @(posedge clk_i);
    ex(2'b00, {app, out_en});
    wb(1'b1, 8'h00, 32'h20, rdat);
    wb(1'b1, 8'h00, 32'h40, rdat);
    repeat (4) @(posedge clk_i);
    ex(2'b11, {app, out_en});
    {prot, on_n} <= 2'b01;
    wb(1'b1, 8'h00, 32'h8, rdat);
    wb(1'b0, 8'h04, 32'h0, rdat);
    ex(2'b01, {rdat[15], out_en});
    repeat (5) @(posedge clk_i);
    stop_test();
  end
endmodule : tb_rael_top
